/* File: hdl/cas_pkg.sv */
// Package with constants, register map and carrier types of the card alarm supervisor.
package cas_pkg;
    localparam int CAS_CLK_HZ = 1000000;
    localparam int CAS_STEPS = 1024;
    localparam int CAS_STEP_W = 10;
    localparam int CAS_DEADMAN_CYCLES = 3;
    localparam int CAS_DEADMAN_STEPS = CAS_STEPS * CAS_DEADMAN_CYCLES;
    localparam int CAS_TMR_W = 12;
    localparam int CAS_MON_W = 8;
    localparam int CAS_DO_N = 4;
    localparam int CAS_ADDR_W = 4;
    localparam logic [3:0] CAS_REG_STATUS = 4'h0;
    localparam logic [3:0] CAS_REG_MASK = 4'h1;
    localparam logic [3:0] CAS_REG_CTRL = 4'h2;
    localparam logic [3:0] CAS_REG_STATE = 4'h3;
    localparam logic [3:0] CAS_REG_STEP = 4'h4;
    localparam int CAS_EV_N = 6;
    localparam int CAS_EV_GEN_FAIL = 0;
    localparam int CAS_EV_PULSE_LOST = 1;
    localparam int CAS_EV_SUPPLY = 2;
    localparam int CAS_EV_CFG = 3;
    localparam int CAS_EV_TROUBLE = 4;
    localparam int CAS_EV_ARITH = 5;
    localparam logic [7:0] CAS_MASK_RST = 8'h00;
    localparam logic [7:0] CAS_CTRL_RST = 8'h00;
    localparam int CAS_CTRL_MSV = 0;
    localparam int CAS_CTRL_MON_EN = 1;

    // Health inputs from the card's supervision points.
    typedef struct packed {
        logic supply_ok;
        logic glue_cfg_done;
        logic op_if_cfg_fail;
        logic overcurrent;
        logic adc_cal_fail;
        logic arith_error;
    } cas_health_s;

    // Front-edge and card-edge alarm drives.
    typedef struct packed {
        logic gen_alarm;
        logic red_led;
        logic relay_drive;
        logic trouble;
        logic amber_led;
    } cas_alarm_s;
endpackage

/* File: hdl/cas_supervisor.sv */
// Alarm and supervision logic: deadman timer, general and trouble alarms, registers.
//
// Function
// - General alarm output held asserted when healthy.
// - Deassert on supply, configuration or pulse loss.
// - Transient arithmetic errors never drop general alarm.
// - Median variant: failure de-energizes relay drive.
// - One monitor pulse at each segment end.
// - Deadman stays up while pulses keep arriving.
// - Pulse stops on clock, code or sequencer failure.
// - Trouble alarm normally deasserted, amber off.
// - Trouble on interface, overcurrent or calibration fault.
// - Trouble alarm drives only local amber indicator.
// - Output indicators follow sinking transistor state.
// - Eight-bit monitor bus active only when enabled.
// - Step counter wraps after 1024 steps.
// - Arithmetic error flags, sequencing continues.
//
// Overview
// The step counter paces the segment and marks its end with a one-cycle pulse.
// That pulse reloads a deadman timer; while the timer is non-zero the pulse path
// is taken as alive.
// The general alarm output is energized only in the healthy state, so a dead card
// or a held reset reads as an alarm at the control room contact; a lost clock leaves it at its last value.
// This fail-safe sense is the reason the drive is active high.
// The trouble alarm is a plain combination of three fault levels and never leaves
// the card; it only lights the amber lamp.
// Arithmetic errors are transient by nature. They are copied to a flag and a status
// bit, but they never reach the general alarm, which would otherwise cause nuisance
// alarms in the control room.
// Every state bit is frozen while the clock enable is low, the deadman included.
// A stalled enable therefore cannot be told apart from a healthy card by this block
// alone; the enable source must be supervised elsewhere.
// Software sees the sticky status, a mask, a control word, the supervisor state and
// the upper step bits over a plain strobe port; reads never stall the master.
// The step register shows only the upper bits, which is enough to see the counter
// move without widening the bus.
// The discrete outputs and their lamps come from the same next value, so a lamp
// can never show a state that its transistor does not have.
`timescale 1ns/1ps
module cas_supervisor
    import cas_pkg::*;
#(
    parameter int STEPS = CAS_STEPS,
    parameter int DEADMAN_STEPS = CAS_DEADMAN_STEPS,
    parameter int DO_N = CAS_DO_N
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire cas_health_s health,
    input wire logic code_valid,
    input wire logic [CAS_MON_W-1:0] mon_node,
    input wire logic [DO_N-1:0] do_cmd,
    input wire logic [DO_N-1:0] output_normally_on,
    input wire logic [CAS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output cas_alarm_s alarm,
    output logic [DO_N-1:0] do_sink_on,
    output logic [DO_N-1:0] do_led,
    output logic [CAS_MON_W-1:0] mon_bus,
    output logic mon_bus_oe,
    output logic seg_pulse,
    output logic arith_err_flag,
    output logic irq,
    output logic [7:0] reg_rdata
);
    localparam logic [CAS_STEP_W-1:0] STEP_LAST = CAS_STEP_W'(STEPS - 1);
    localparam logic [CAS_TMR_W-1:0] TMR_LOAD = CAS_TMR_W'(DEADMAN_STEPS);
    localparam logic [CAS_TMR_W-1:0] TMR_ZERO = '0;

    typedef enum logic [1:0]
    {
        CAS_ST_STARTUP = 2'b00,
        CAS_ST_HEALTHY = 2'b01,
        CAS_ST_FAILED = 2'b10
    } cas_state_e;

    // Healthy-state test; shared by the three alarm drives, so they disagree only when a clear median-variant bit holds the relay drive off.
    function automatic logic st_is_healthy(input cas_state_e st);
        return st == CAS_ST_HEALTHY;
    endfunction

    // Sink state per channel: a normally-on channel conducts while its command is low,
    // so the polarity input simply inverts the command bit for that channel.
    function automatic logic [DO_N-1:0] sink_map(input logic [DO_N-1:0] cmd,
        input logic [DO_N-1:0] pol);
        return cmd ^ pol;
    endfunction

    cas_state_e state_q;
    cas_state_e state_d;
    logic [CAS_STEP_W-1:0] step_q;
    logic [CAS_TMR_W-1:0] tmr_q;
    logic pulse_q;
    logic pulse_seen_q;
    logic [7:0] status_q;
    logic [7:0] mask_q;
    logic [7:0] ctrl_q;

    // Step counter wraps each segment; its last step marks the segment end.
    wire seg_end = code_valid && (step_q == STEP_LAST);
    wire deadman_ok = (tmr_q != TMR_ZERO);
    // Only permanent failures feed the general alarm; arithmetic error is left out.
    wire healthy = health.supply_ok && health.glue_cfg_done && deadman_ok;
    wire trouble = health.op_if_cfg_fail || health.overcurrent
        || health.adc_cal_fail;
    wire msv = ctrl_q[CAS_CTRL_MSV];
    wire mon_en = ctrl_q[CAS_CTRL_MON_EN];
    // Next-state view of health, so the alarm drives change on the same edge as the state.
    wire healthy_next = st_is_healthy(state_d);
    // Sink pattern for this cycle's commands.
    wire [DO_N-1:0] sink_d = sink_map(do_cmd, output_normally_on);

    // Register decode.
    // Writes to unmapped or read-only offsets fall through and change nothing.
    wire wr_status = reg_wr && (reg_addr == CAS_REG_STATUS);
    wire wr_mask = reg_wr && (reg_addr == CAS_REG_MASK);
    wire wr_ctrl = reg_wr && (reg_addr == CAS_REG_CTRL);

    // Event vector for the sticky status bits.
    // Level events re-set their bit every cycle, so a clear only sticks once the
    // cause has gone away.
    wire [7:0] ev;
    assign ev[CAS_EV_GEN_FAIL] = (state_q == CAS_ST_HEALTHY) && !healthy;
    assign ev[CAS_EV_PULSE_LOST] = pulse_seen_q && !deadman_ok;
    assign ev[CAS_EV_SUPPLY] = !health.supply_ok;
    assign ev[CAS_EV_CFG] = !health.glue_cfg_done;
    assign ev[CAS_EV_TROUBLE] = trouble;
    assign ev[CAS_EV_ARITH] = health.arith_error;
    assign ev[7:CAS_EV_N] = '0;

    // Set wins over a write-one clear in the same cycle.
    wire [7:0] status_d = (status_q & ~(wr_status ? reg_wdata : 8'h00)) | ev;

    // Read mux; unmapped addresses read zero.
    // Reading has no side effect, so software may poll status freely.
    wire [7:0] rd_mux =
        (reg_addr == CAS_REG_STATUS) ? status_q :
        (reg_addr == CAS_REG_MASK) ? mask_q :
        (reg_addr == CAS_REG_CTRL) ? ctrl_q :
        (reg_addr == CAS_REG_STATE) ? {6'h00, state_q} :
        (reg_addr == CAS_REG_STEP) ? step_q[CAS_STEP_W-1:2] :
        8'h00;

    // Startup waits for a first pulse so a fresh card does not alarm as healthy early.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CAS_ST_STARTUP:
            begin
                if (healthy && pulse_seen_q)
                    state_d = CAS_ST_HEALTHY;
            end
            CAS_ST_HEALTHY:
            begin
                if (!healthy)
                    state_d = CAS_ST_FAILED;
            end
            CAS_ST_FAILED:
            begin
                if (healthy)
                    state_d = CAS_ST_HEALTHY;
            end
            // The unused code can only come from an upset; restart cleanly from it.
            default:
                state_d = CAS_ST_STARTUP;
        endcase
    end

    // Segment step counter; holds when no control codes arrive, so the pulse stops.
    // The wrap comes from the last-step compare, not from overflow, so the count
    // stays right for a segment length that is not a power of two.
    always_ff @(posedge mclk)
    begin
        if (rst)
            step_q <= '0;
        else if (clk_en && code_valid)
            step_q <= seg_end ? '0 : step_q + 1'b1;
    end

    // Deadman timer reloads on each pulse and runs down otherwise.
    // It stops at zero rather than wrapping, so an expired deadman stays expired
    // until a fresh pulse arrives.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tmr_q <= '0;
            pulse_q <= 1'b0;
            pulse_seen_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pulse_q <= seg_end;
            if (pulse_q)
            begin
                tmr_q <= TMR_LOAD;
                pulse_seen_q <= 1'b1;
            end
            else if (deadman_ok)
                tmr_q <= tmr_q - 1'b1;
        end
    end

    // Supervisor state.
    // Held in reset so the card always comes up in startup and waits for a pulse.
    always_ff @(posedge mclk)
    begin
        if (rst)
            state_q <= CAS_ST_STARTUP;
        else if (clk_en)
            state_q <= state_d;
    end

    // Registers and interrupt.
    // The read data register returns zero when no read is pending, keeping the bus quiet.
    // The interrupt uses the next status so it rises on the same edge as the bit.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_q <= '0;
            mask_q <= CAS_MASK_RST;
            ctrl_q <= CAS_CTRL_RST;
            reg_rdata <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            status_q <= status_d;
            if (wr_mask)
                mask_q <= reg_wdata;
            if (wr_ctrl)
                ctrl_q <= reg_wdata;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq <= |(status_d & mask_q);
        end
    end

    // Alarm drives; the trouble alarm reaches only the local amber lamp.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            alarm <= '0;
            seg_pulse <= 1'b0;
            arith_err_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            alarm.gen_alarm <= healthy_next;
            alarm.red_led <= healthy_next;
            // The relay is energized only in the median variant and only while healthy,
            // so any failure or a fresh power-up lets it fall to the default input.
            alarm.relay_drive <= msv && healthy_next;
            alarm.trouble <= trouble;
            alarm.amber_led <= trouble;
            seg_pulse <= seg_end;
            arith_err_flag <= health.arith_error;
        end
    end

    // Discrete outputs: normally-on channels invert the command; lamps follow the transistor.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            do_sink_on <= '0;
            do_led <= '0;
        end
        else if (clk_en)
        begin
            do_sink_on <= sink_d;
            do_led <= sink_d;
        end
    end

    // Monitor bus drives internal nodes only while enabled, for the factory tester.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mon_bus <= '0;
            mon_bus_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            mon_bus <= mon_en ? mon_node : '0;
            mon_bus_oe <= mon_en;
        end
    end
endmodule

/* File: tb/cas_supervisor_sva.sv */
// Port checker for the card alarm supervisor.
`timescale 1ns/1ps
module cas_supervisor_chk
    import cas_pkg::*;
#(
    parameter int DO_N = CAS_DO_N
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire cas_health_s health,
    input wire logic [DO_N-1:0] do_cmd,
    input wire logic [DO_N-1:0] output_normally_on,
    input wire cas_alarm_s alarm,
    input wire logic [DO_N-1:0] do_sink_on,
    input wire logic [DO_N-1:0] do_led,
    input wire logic [CAS_MON_W-1:0] mon_bus,
    input wire logic mon_bus_oe,
    input wire logic seg_pulse
);
    // One clock domain, so clocking and reset are set once.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Any of the three trouble faults.
    wire logic flt = health.op_if_cfg_fail | health.overcurrent | health.adc_cal_fail;

    a_trouble_set: assert property (clk_en && flt |=> alarm.trouble)
        else $error("trouble not raised");
    a_trouble_idle: assert property (clk_en && !flt |=> !alarm.trouble)
        else $error("trouble raised without fault");
    a_amber_follow: assert property (alarm.amber_led == alarm.trouble)
        else $error("amber differs from trouble");
    a_red_follow: assert property (alarm.red_led == alarm.gen_alarm)
        else $error("red differs from general alarm");
    a_supply_drop: assert property (clk_en && !health.supply_ok |=> !alarm.gen_alarm)
        else $error("alarm kept on supply loss");
    a_cfg_drop: assert property (clk_en && !health.glue_cfg_done |=> !alarm.gen_alarm)
        else $error("alarm kept on config loss");
    a_relay_fail: assert property (!alarm.gen_alarm |-> !alarm.relay_drive)
        else $error("relay energized in failure");
    a_dout_map: assert property (clk_en |=> do_sink_on == $past(do_cmd ^ output_normally_on)
        && do_led == do_sink_on)
        else $error("sink output wrong");
    a_mon_quiet: assert property (!mon_bus_oe |-> mon_bus == 8'h00)
        else $error("monitor bus active while off");
    a_pulse_single: assert property (seg_pulse |=> !seg_pulse)
        else $error("segment pulse longer than one cycle");
endmodule
bind cas_supervisor cas_supervisor_chk #(.DO_N(DO_N)) chk_u (.mclk, .rst, .clk_en, .health,
    .do_cmd, .output_normally_on, .alarm, .do_sink_on, .do_led, .mon_bus, .mon_bus_oe,
    .seg_pulse);

/* File: tb/cas_annunciator.sv */
// Control room annunciator wired to the card-edge alarm contact.
`timescale 1ns/1ps
module cas_annunciator
(
    input wire logic gen_alarm,
    output logic horn
);
    // The contact is grounded while the output is dropped, so the room alarms then.
    assign horn = ~gen_alarm;
endmodule

/* File: tb/tb_cas_supervisor.sv */
// Self-checking testbench for the card alarm supervisor.
`timescale 1ns/1ps
module tb_cas_supervisor
    import cas_pkg::*;
;
    logic mclk = 0, rst = 1, clk_en = 1, code_valid = 1, wr = 0, rd = 0, irq, sp, aef, oe, horn;
    cas_health_s h = 6'h30;
    cas_alarm_s al;
    logic [7:0] mon = 8'h00, wd = 8'h00, rdat, mb, v, csum = 8'h00, msum = 8'h00;
    logic [3:0] addr = 4'h0, cmd = 4'h0, pol = 4'h0, sink, led;
    logic [31:0] seed = 32'h7ACA;
    int err_total = 0, samples_checked = 0;

    // Small counts keep the deadman run short.
    cas_supervisor #(.STEPS(8), .DEADMAN_STEPS(24)) dut_u (.mclk, .rst, .clk_en, .health(h),
        .code_valid, .mon_node(mon), .do_cmd(cmd), .output_normally_on(pol), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .alarm(al), .do_sink_on(sink), .do_led(led),
        .mon_bus(mb), .mon_bus_oe(oe), .seg_pulse(sp), .arith_err_flag(aef), .irq,
        .reg_rdata(rdat));
    cas_annunciator ann_u (.gen_alarm(al.gen_alarm), .horn);

    // Clock and a watchdog that cuts a hang short.
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        #200000;
        err_total++;
        conclude();
    end

    // Helpers: random source, compare, bus cycles and waits.
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask
    task automatic wait_up();
        for (int i = 0; i < 80 && al.gen_alarm !== 1'b1; i++)
            cyc(1);
        chk("gen_up", 8'h01, {7'h00, al.gen_alarm});
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence of scenarios.
    initial
    begin
        int n;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        wait_up();
        chk("trb", 8'h00, {7'h00, al.trouble});
        for (n = 0; n < 20 && sp !== 1'b1; n++)
            cyc(1);
        for (n = 1; n < 20; n++)
        begin
            cyc(1);
            if (sp === 1'b1)
                break;
        end
        chk("period", 8'h08, n[7:0]);
        // Random arithmetic errors must not drop the alarm.
        repeat (40)
        begin
            @(posedge mclk);
            v = rnd();
            h.arith_error <= v[0];
            {pol, cmd} <= v;
            mon <= v;
            cyc(1);
            chk("sink", 8'h00, {4'h0, sink ^ cmd ^ pol});
            chk("aef", {7'h00, h.arith_error}, {7'h00, aef});
            chk("gen", 8'h01, {7'h00, al.gen_alarm});
        end
        h.arith_error <= 1'b0;
        // Each trouble fault alone lights amber but leaves the contact alone.
        for (int k = 0; k < 3; k++)
        begin
            h[3:1] <= 3'h1 << k;
            cyc(2);
            chk("amber", 8'h01, {7'h00, al.amber_led});
            chk("gen", 8'h01, {7'h00, al.gen_alarm});
            h[3:1] <= 3'h0;
            cyc(2);
            chk("amber_off", 8'h00, {7'h00, al.amber_led});
        end
        wr_reg(CAS_REG_CTRL, 8'h03);
        wr_reg(CAS_REG_MASK, 8'h04);
        cyc(2);
        chk("relay", 8'h01, {7'h00, al.relay_drive});
        chk("mbus", mon, mb);
        rd_reg(CAS_REG_CTRL, v);
        chk("ctrl", 8'h03, v);
        // Tester side: sample the bus, compare each value and a running checksum.
        for (int k = 0; k < 8; k++)
        begin
            v = rnd();
            mon <= v;
            csum += v;
            cyc(1);
            msum += mb;
            chk("mbus", mon, mb);
        end
        chk("msum", csum, msum);
        rd_reg(4'h9, v);
        chk("unmap", 8'h00, v);
        // Supply loss, then recovery and interrupt clear.
        h.supply_ok <= 1'b0;
        cyc(2);
        chk("relay", 8'h00, {7'h00, al.relay_drive});
        chk("horn", 8'h01, {7'h00, horn});
        chk("irq", 8'h01, {7'h00, irq});
        h.supply_ok <= 1'b1;
        wait_up();
        wr_reg(CAS_REG_STATUS, 8'h3F);
        wr_reg(CAS_REG_CTRL, 8'h00);
        cyc(2);
        chk("irq", 8'h00, {7'h00, irq});
        chk("mbus", 8'h00, mb);
        h.glue_cfg_done <= 1'b0;
        cyc(2);
        chk("gen", 8'h00, {7'h00, al.gen_alarm});
        h.glue_cfg_done <= 1'b1;
        wait_up();
        // Pulse loss: one late segment tolerated, stopped pulses caught.
        code_valid <= 1'b0;
        cyc(12);
        chk("gen", 8'h01, {7'h00, al.gen_alarm});
        cyc(20);
        chk("gen", 8'h00, {7'h00, al.gen_alarm});
        code_valid <= 1'b1;
        wait_up();
        // A low clock enable freezes the deadman, so a long stall keeps the alarm.
        clk_en <= 1'b0;
        cyc(40);
        chk("frz", 8'h01, {7'h00, al.gen_alarm});
        clk_en <= 1'b1;
        // A reset in mid-run drops the alarm, and the card restarts by itself.
        rst <= 1'b1;
        cyc(2);
        chk("rstgen", 8'h00, {7'h00, al.gen_alarm});
        rst <= 1'b0;
        wait_up();
        conclude();
    end
endmodule
